// ### hdl/qcc_pkg.sv
// Package with constants for the quadrature counter cascade read block
package qcc_pkg;
   localparam int          CNT_W        = 32;
   localparam int          BYTE_W       = 8;
   localparam int          AXES         = 2;
   localparam logic [31:0] CNT_RST      = 32'h0000_0000;
   localparam logic [31:0] CNT_MAX      = 32'hFFFF_FFFF;
   // Byte select codes {high_line, low_line}
   localparam logic [1:0]  SEL_MSB      = 2'h2;
   localparam logic [1:0]  SEL_2ND      = 2'h3;
   localparam logic [1:0]  SEL_3RD      = 2'h0;
   localparam logic [1:0]  SEL_LSB      = 2'h1;
   // Count mode codes {cfg_b, cfg_a}
   localparam logic [1:0]  MODE_4X      = 2'h1;
   localparam logic [1:0]  MODE_2X      = 2'h2;
   localparam logic [1:0]  MODE_1X      = 2'h3;
   // Avalon register offsets (byte addresses)
   localparam logic [3:0]  REG_CTRL     = 4'h0;
   localparam logic [3:0]  REG_STATUS   = 4'h4;
   localparam logic [3:0]  REG_CLEAR    = 4'h8;
   localparam logic [3:0]  REG_ENABLE   = 4'hC;
   // Control fields
   localparam int          CTRL_UP_BIT  = 0;
   localparam int          CTRL_DN_BIT  = 1;
   localparam int          CTRL_RUN_BIT = 2;
   // Event bits
   localparam int          EV_CAS_BIT   = 0;
   localparam int          EV_INH_BIT   = 1;
   localparam int          EV_W         = 2;
   localparam logic [31:0] UNMAPPED_RD  = 32'h0000_0000;
endpackage : qcc_pkg

// ### hdl/quad_counter_cascade_read.sv
// Position counter, latch with read inhibit, byte mux and cascade pulse
// What the document requires of this block, its host and the external cascade logic
// RULE_01 - A counter rollover on a rising edge updates the counter and emits a cascade count pulse just after.
// RULE_02 - Byte select and output enable low at a falling edge inhibit the latch until released.
// RULE_03 - The external logic latches its own counter when the high byte read begins, never later.
// RULE_04 - A cascade pulse in the cycle a read starts is still counted externally, consistent with the latch.
// RULE_05 - A read starting in a rollover cycle returns the pre-rollover count.
// RULE_06 - Output enable low seen at a falling edge sets the inhibit; latched bytes read at any phase.
// RULE_07 - Output enable high seen at a falling edge tristates the data lines and releases the inhibit.
// RULE_08 - The rising edge after release loads the counter into the latch again.
// RULE_09 - The host sets 4x count mode and the axis select before reading.
// RULE_10 - The host assembles four bytes, first most significant, into 32 bits.
// RULE_11 - Byte selects step low-high, high-high, low-low, high-low with output enable low.
// RULE_12 - Uninhibited, the latch captures the counter every rising edge; reset clears it to zero.
// RULE_13 - The host accepts a byte only after two equal consecutive samples.
//
// Implementation choices: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ps
module quad_counter_cascade_read
   import qcc_pkg::*;
(
   input  wire logic                      clk_i,
   input  wire logic                      srst_i,
   input  wire logic                      byte_select_low_line_i,
   input  wire logic                      byte_select_high_line_i,
   input  wire logic                      oe_n_i,
   input  wire logic                      count_mode_cfg_a_i,
   input  wire logic                      count_mode_cfg_b_i,
   input  wire logic                      axis_sel_i,
   input  wire logic                      avs_read_i,
   input  wire logic                      avs_write_i,
   input  wire logic [3:0]                avs_address_i,
   input  wire logic [31:0]               avs_writedata_i,
   input  wire logic [3:0]                avs_byteenable_i,
   output logic      [31:0]               avs_readdata_o,
   output logic                           avs_waitrequest_o,
   output logic      [qcc_pkg::BYTE_W-1:0] data_o,
   output logic      [qcc_pkg::BYTE_W-1:0] data_oe_o,
   output logic                           cascade_count_pulse_o,
   output logic                           cascade_up_o,
   output logic                           irq_o
);
   import qcc_pkg::*;

   typedef enum logic [1:0] {BUS_IDLE, BUS_ACK} bus_state_t;

   // Pins from the host are asynchronous to clk_i
   logic sel_lo_s, sel_hi_s, oe_n_s, cfg_a_s, cfg_b_s, axis_s;
   sync2 u_sync_sl (.clk_i(clk_i), .srst_i(srst_i), .d_i(byte_select_low_line_i),  .q_o(sel_lo_s));
   sync2 u_sync_sh (.clk_i(clk_i), .srst_i(srst_i), .d_i(byte_select_high_line_i), .q_o(sel_hi_s));
   // Output enable idles high; a low reset value would fake a read
   // and inhibit the latch right after every reset
   sync2 #(.RST_VAL(1'b1)) u_sync_oe (.clk_i(clk_i), .srst_i(srst_i), .d_i(oe_n_i), .q_o(oe_n_s));
   sync2 u_sync_ca (.clk_i(clk_i), .srst_i(srst_i), .d_i(count_mode_cfg_a_i),      .q_o(cfg_a_s));
   sync2 u_sync_cb (.clk_i(clk_i), .srst_i(srst_i), .d_i(count_mode_cfg_b_i),      .q_o(cfg_b_s));
   sync2 u_sync_ax (.clk_i(clk_i), .srst_i(srst_i), .d_i(axis_sel_i),              .q_o(axis_s));

   // Registers
   logic [2:0]       ctrl_q;
   logic [EV_W-1:0]  status_q, enable_q;
   logic [CNT_W-1:0] cnt_q   [AXES];
   logic [CNT_W-1:0] latch_q [AXES];
   logic             inhibit_n_q;
   logic             inhibit_q;
   logic             inhibit_prev_q;
   logic             cas_q, cas_up_q;
   logic [BYTE_W-1:0] data_q, data_oe_q;
   bus_state_t       bus_q;
   logic [31:0]      rdata_q;

   // Count steps from software; mode only gates the step, one step per cycle in any valid mode
   wire  [1:0] mode_w   = {cfg_b_s, cfg_a_s};
   wire        step_w   = ctrl_q[CTRL_RUN_BIT] & (ctrl_q[CTRL_UP_BIT] ^ ctrl_q[CTRL_DN_BIT]);
   wire        dir_up_w = ctrl_q[CTRL_UP_BIT];
   wire        mode_ok_w = (mode_w == MODE_4X) | (mode_w == MODE_2X) | (mode_w == MODE_1X);
   wire        cnt_en_w = step_w & mode_ok_w;

   // Rollover detect on the selected axis drives the cascade pulse
   wire [CNT_W-1:0] cnt_sel_w = cnt_q[axis_s];
   wire        roll_w   = cnt_en_w & (dir_up_w ? (cnt_sel_w == CNT_MAX) : (cnt_sel_w == CNT_RST));

   // Falling-edge inhibit sampling
   wire        sel_read_w = ~oe_n_s;
   always_ff @(negedge clk_i) begin
      if (srst_i) begin
         inhibit_n_q <= 1'b0;
      end else begin
         inhibit_n_q <= sel_read_w; // RULE_02 RULE_06 RULE_07
      end
   end
   // Bring the falling-edge flag back to the rising domain of the same clock
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         inhibit_q      <= 1'b0;
         inhibit_prev_q <= 1'b0;
      end else begin
         inhibit_q      <= inhibit_n_q;
         inhibit_prev_q <= inhibit_q;
      end
   end
   // Latch holds from the falling edge that sets the inhibit; the first
   // rising edge after release loads it again, with no extra cycle of hold
   wire latch_hold_w = inhibit_n_q;

   genvar ax;
   generate
      for (ax = 0; ax < AXES; ax++) begin : g_axis
         wire sel_ax_w = (axis_s == 1'(ax));
         always_ff @(posedge clk_i) begin
            if (srst_i) begin
               cnt_q[ax]   <= CNT_RST;
               latch_q[ax] <= CNT_RST; // RULE_12
            end else begin
               if (cnt_en_w && sel_ax_w) begin
                  cnt_q[ax] <= dir_up_w ? cnt_q[ax] + 32'h1 : cnt_q[ax] - 32'h1; // RULE_01
               end
               if (!latch_hold_w) begin
                  latch_q[ax] <= cnt_q[ax]; // RULE_12 RULE_08 RULE_05
               end
            end
         end
      end
   endgenerate

   // Byte mux
   wire [1:0]        sel_w = {sel_hi_s, sel_lo_s};
   wire [CNT_W-1:0]  lat_w = latch_q[axis_s];
   wire [BYTE_W-1:0] byte_w =
      (sel_w == SEL_MSB) ? lat_w[31:24] :
      (sel_w == SEL_2ND) ? lat_w[23:16] :
      (sel_w == SEL_3RD) ? lat_w[15:8]  : lat_w[7:0]; // RULE_11

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         data_q    <= 8'h00;
         data_oe_q <= 8'h00;
         cas_q     <= 1'b0;
         cas_up_q  <= 1'b1;
      end else begin
         // Registered pulse trails the rollover edge by clock-to-out only
         data_q    <= byte_w;
         data_oe_q <= {BYTE_W{inhibit_n_q}}; // RULE_07
         cas_q     <= roll_w; // RULE_01
         if (cnt_en_w) begin
            cas_up_q <= dir_up_w;
         end
      end
   end

   // Events: rollover and start of inhibit; set wins over clear
   wire [EV_W-1:0] ev_w;
   assign ev_w[EV_CAS_BIT] = roll_w;
   assign ev_w[EV_INH_BIT] = inhibit_q & ~inhibit_prev_q;

   // Avalon slave: one wait cycle, then the answer
   wire req_w  = (avs_read_i | avs_write_i) & (bus_q == BUS_IDLE);
   wire wr_w   = avs_write_i & (bus_q == BUS_ACK);
   wire wr_ctl = wr_w & (avs_address_i == REG_CTRL) & avs_byteenable_i[0];
   wire wr_clr = wr_w & (avs_address_i == REG_CLEAR) & avs_byteenable_i[0];
   wire wr_en  = wr_w & (avs_address_i == REG_ENABLE) & avs_byteenable_i[0];
   wire [31:0] rd_mux_w =
      (avs_address_i == REG_CTRL)   ? {29'h0, ctrl_q} :
      (avs_address_i == REG_STATUS) ? {30'h0, status_q} :
      (avs_address_i == REG_ENABLE) ? {30'h0, enable_q} : UNMAPPED_RD;

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         bus_q    <= BUS_IDLE;
         rdata_q  <= 32'h0000_0000;
         ctrl_q   <= 3'h0;
         status_q <= 2'h0;
         enable_q <= 2'h0;
      end else begin
         case (bus_q)
            BUS_IDLE: begin
               if (req_w) begin
                  bus_q   <= BUS_ACK;
                  rdata_q <= rd_mux_w;
               end
            end
            BUS_ACK: bus_q <= BUS_IDLE;
            default: bus_q <= BUS_IDLE;
         endcase
         if (wr_ctl) begin
            ctrl_q <= avs_writedata_i[2:0];
         end
         if (wr_en) begin
            enable_q <= avs_writedata_i[EV_W-1:0];
         end
         status_q <= (status_q & ~(wr_clr ? avs_writedata_i[EV_W-1:0] : 2'h0)) | ev_w;
      end
   end

   // Registered, so the level trails its status bit by one cycle
   logic irq_q;
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(status_q & enable_q);
      end
   end

   // Waitrequest is low only in the answer cycle
   // Read data were taken at the accepting edge and stand through it
   logic wait_q;
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         wait_q <= 1'b1;
      end else begin
         wait_q <= ~req_w;
      end
   end

   assign avs_readdata_o        = rdata_q;
   assign avs_waitrequest_o     = wait_q;
   assign data_o                = data_q;
   assign data_oe_o             = data_oe_q;
   assign cascade_count_pulse_o = cas_q;
   assign cascade_up_o          = cas_up_q;
   assign irq_o                 = irq_q;
endmodule : quad_counter_cascade_read

// ### hdl/sync2.sv
// Two flip-flop synchroniser for one bit
`timescale 1ns/1ps
module sync2 #(
   parameter logic RST_VAL = 1'b0
) (
   input  wire logic clk_i,
   input  wire logic srst_i,
   input  wire logic d_i,
   output logic      q_o
);
   logic meta_q;
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         meta_q <= RST_VAL;
         q_o    <= RST_VAL;
      end else begin
         meta_q <= d_i;
         q_o    <= meta_q;
      end
   end
endmodule : sync2

// ### verif/cascade_host_model.sv
// Host reader plus external cascade counter and latch
`timescale 1ns/1ps
module cascade_host_model
   import qcc_pkg::*;
#(
   parameter int GAP = 8
) (
   input  wire logic       clk_i,
   input  wire logic       start_i,
   input  wire logic       cas_i,
   input  wire logic       cas_up_i,
   input  wire logic [7:0] data_i,
   output logic            sel_lo_o,
   output logic            sel_hi_o,
   output logic            oe_n_o,
   output logic [1:0]      mode_o,
   output logic            axis_o,
   output logic            done_o,
   output logic [31:0]     pos_o,
   output logic [7:0]      ext_latch_o
);
   logic [7:0] ext_q;
   logic [7:0] b [4];
   initial begin
      {sel_hi_o, sel_lo_o, oe_n_o, done_o, pos_o, ext_q} = {3'h7, 1'h0, 32'h0, 8'hF0};
      mode_o = MODE_4X;
      axis_o = 1'b0;
   end
   // Pulse in the read-start cycle still counted
   always @(posedge clk_i) if (cas_i === 1'b1) ext_q <= cas_up_i ? ext_q + 8'h01 : ext_q - 8'h01;
   // Synced selects lag, so wait GAP before trusting samples
   task get_byte(input logic [1:0] s, output logic [7:0] v);
      logic [7:0] a;
      {sel_hi_o, sel_lo_o} <= s;
      do begin
         repeat (GAP) @(posedge clk_i);
         a = data_i;
         @(posedge clk_i);
         v = data_i;
      end while (a !== v);
   endtask : get_byte
   always @(posedge clk_i) if (start_i === 1'b1) begin
      oe_n_o <= 1'b0;
      ext_latch_o <= ext_q;
      get_byte(SEL_MSB, b[3]);
      get_byte(SEL_2ND, b[2]);
      get_byte(SEL_3RD, b[1]);
      get_byte(SEL_LSB, b[0]);
      oe_n_o <= 1'b1;
      pos_o <= {b[3], b[2], b[1], b[0]};
      done_o <= 1'b1;
      @(posedge clk_i);
      done_o <= 1'b0;
   end
endmodule : cascade_host_model

// ### verif/quad_counter_cascade_read_checker.sv
// Port-level assertions for the cascade read block
`timescale 1ns/1ps
module qcc_checker
   import qcc_pkg::*;
(
   input wire logic                      clk_i,
   input wire logic                      srst_i,
   input wire logic                      byte_select_low_line_i,
   input wire logic                      byte_select_high_line_i,
   input wire logic                      oe_n_i,
   input wire logic                      avs_read_i,
   input wire logic                      avs_write_i,
   input wire logic                      avs_waitrequest_o,
   input wire logic [qcc_pkg::BYTE_W-1:0] data_o,
   input wire logic [qcc_pkg::BYTE_W-1:0] data_oe_o,
   input wire logic                      cascade_count_pulse_o,
   input wire logic                      irq_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (srst_i);
   bus_answer_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
      else $error("bus answer late");
   answer_one_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o) else $error("answer held");
   answer_cause_a: assert property ($fell(avs_waitrequest_o) |-> $past(avs_read_i || avs_write_i))
      else $error("answer without request");
   cascade_pulse_a: assert property (cascade_count_pulse_o |=> !cascade_count_pulse_o)
      else $error("cascade pulse too long");
   inhibit_set_a: assert property ((!oe_n_i) [*6] |-> data_oe_o == 8'hFF)
      else $error("no drive while read");
   inhibit_free_a: assert property (oe_n_i [*6] |-> data_oe_o == 8'h00)
      else $error("bus not released");
   latch_frozen_a: assert property (
      (!oe_n_i && $stable({byte_select_high_line_i, byte_select_low_line_i})) [*8] |-> $stable(data_o))
      else $error("byte moved while inhibited");
   reset_out_a: assert property ($fell(srst_i) |-> avs_waitrequest_o && !irq_o && !cascade_count_pulse_o)
      else $error("bad reset outputs");
endmodule : qcc_checker

bind quad_counter_cascade_read qcc_checker u_chk (.clk_i, .srst_i, .byte_select_low_line_i,
   .byte_select_high_line_i, .oe_n_i, .avs_read_i, .avs_write_i, .avs_waitrequest_o, .data_o, .data_oe_o,
   .cascade_count_pulse_o, .irq_o);

// ### verif/quad_counter_cascade_read_test.sv
// Self-checking bench for the cascade read block
`timescale 1ns/1ps
module quad_counter_cascade_read_test;
   import qcc_pkg::*;
   logic clk_i, srst_i, byte_select_low_line_i, byte_select_high_line_i, oe_n_i, avs_read_i, avs_write_i, start;
   logic [1:0]  mode;
   logic [3:0]  avs_address_i;
   logic [31:0] avs_writedata_i, avs_readdata_o, r, pos, mpos;
   logic [7:0]  data_o, data_oe_o, ext, seen;
   logic        avs_waitrequest_o, cascade_count_pulse_o, cascade_up_o, irq_o, done, axis;
   logic [31:0] mcnt;
   logic [2:0]  mctrl;
   int          miscompares, samples_checked, ncas, k;
   quad_counter_cascade_read dut (.clk_i, .srst_i, .byte_select_low_line_i, .byte_select_high_line_i, .oe_n_i,
      .count_mode_cfg_a_i(mode[0]), .count_mode_cfg_b_i(mode[1]), .axis_sel_i(axis), .avs_read_i, .avs_write_i,
      .avs_address_i, .avs_writedata_i, .avs_byteenable_i(4'hF), .avs_readdata_o, .avs_waitrequest_o, .data_o,
      .data_oe_o, .cascade_count_pulse_o, .cascade_up_o, .irq_o);
   // Undriven bus shows a changing inverse, never a stale byte
   assign seen = (data_oe_o === 8'hFF) ? data_o : ~data_o;
   cascade_host_model #(.GAP(8)) host (.clk_i, .start_i(start), .cas_i(cascade_count_pulse_o),
      .cas_up_i(cascade_up_o), .data_i(seen), .sel_lo_o(byte_select_low_line_i),
      .sel_hi_o(byte_select_high_line_i), .oe_n_o(oe_n_i), .mode_o(mode), .done_o(done), .pos_o(pos),
      .ext_latch_o(ext), .axis_o(axis));
   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end
   always @(posedge clk_i) if (cascade_count_pulse_o === 1'b1) ncas++;
   // Reference counter: one step per edge while run and exactly one direction are set
   always @(posedge clk_i) begin
      if (srst_i === 1'b1) begin
         mcnt  <= CNT_RST;
         mctrl <= 3'h0;
      end else begin
         if (mctrl[CTRL_RUN_BIT] && (mctrl[CTRL_UP_BIT] != mctrl[CTRL_DN_BIT])) begin
            mcnt <= mctrl[CTRL_UP_BIT] ? mcnt + 32'h1 : mcnt - 32'h1;
         end
         if (avs_write_i === 1'b1 && avs_waitrequest_o === 1'b0 && avs_address_i == REG_CTRL) begin
            mctrl <= avs_writedata_i[2:0];
         end
      end
   end
   task chk(input logic [31:0] s, input logic [31:0] e);
      samples_checked++;
      if (s !== e) begin
         miscompares++;
         $display("Error %0t: seen %h expected %h", $time, s, e);
      end
   endtask : chk
   task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      avs_read_i <= !w;
      avs_write_i <= w;
      avs_address_i <= a;
      avs_writedata_i <= d;
      do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
      r = avs_readdata_o;
      avs_read_i <= 1'b0;
      avs_write_i <= 1'b0;
      @(posedge clk_i);
   endtask : bus
   task host_read();
      start <= 1'b1;
      @(posedge clk_i);
      start <= 1'b0;
      do @(posedge clk_i); while (done !== 1'b1);
      @(posedge clk_i);
   endtask : host_read
   task end_sim();
      if (miscompares == 0 && samples_checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : end_sim
   initial begin
      repeat (20000) @(posedge clk_i);
      miscompares++;
      end_sim();
   end
   initial begin
      {srst_i, avs_read_i, avs_write_i, start, avs_address_i, avs_writedata_i} = {1'b1, 39'h0};
      void'($urandom(32'h39B50E6E));
      k = 5 + $urandom % 20;
      repeat (2) @(posedge clk_i);
      srst_i <= 1'b0;
      @(posedge clk_i);
      bus(1'b0, REG_STATUS, 32'h0);
      chk(r, 32'h0);
      bus(1'b1, REG_ENABLE, 32'h3);
      bus(1'b0, REG_ENABLE, 32'h0);
      chk(r, 32'h3);
      bus(1'b0, 4'h2, 32'h0);
      chk(r, UNMAPPED_RD);
      // Down from zero underflows on the first step
      avs_read_i <= 1'b0;
      avs_write_i <= 1'b1;
      avs_address_i <= REG_CTRL;
      avs_writedata_i <= 32'h6;
      do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
      avs_write_i <= 1'b0;
      repeat (k) @(posedge clk_i);
      bus(1'b1, REG_CTRL, 32'h0);
      mpos = 32'h0 - (k + 2);
      chk(ncas, 1);
      chk(cascade_up_o, 1'b0);
      host_read();
      chk(pos, mpos);
      chk(ext, 8'hEF);
      host_read();
      chk(pos, mpos);
      bus(1'b0, REG_STATUS, 32'h0);
      chk(r, 32'h3);
      chk(irq_o, 1'b1);
      bus(1'b1, REG_ENABLE, 32'h0);
      @(posedge clk_i);
      chk(irq_o, 1'b0);
      bus(1'b1, REG_ENABLE, 32'h3);
      bus(1'b1, REG_CLEAR, 32'h3);
      bus(1'b0, REG_STATUS, 32'h0);
      chk(r, 32'h0);
      chk(irq_o, 1'b0);
      // Read while counting: latch must hold
      bus(1'b1, REG_CTRL, 32'h6);
      host_read();
      bus(1'b1, REG_CTRL, 32'h0);
      chk(pos[31:16], 16'hFFFF);
      // Reset with the count stopped, then a read that starts in the rollover cycle
      srst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      srst_i <= 1'b0;
      @(posedge clk_i);
      chk(data_oe_o, 8'h00);
      fork
         host_read();
         bus(1'b1, REG_CTRL, 32'h6);
      join
      chk(pos, CNT_RST);
      chk(ext, 8'hEF);
      bus(1'b1, REG_CTRL, 32'h0);
      chk(ncas, 2);
      host_read();
      chk(pos, mcnt);
      chk(ext, 8'hEE);
      end_sim();
   end
endmodule : quad_counter_cascade_read_test
